// *** hw/rfs_sequencer.sv ***
// rfs_sequencer: start-up, soft-start and fault supervision of a buck regulator
// assumes comparator inputs synchronous to aclk and osc_tick one pulse per switching cycle
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rfs_sequencer
	import rfs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic osc_tick,
	input wire logic supply_lockout,
	input wire logic en_above_rise,
	input wire logic en_above_fall,
	input wire logic feedback_sense_short,
	input wire logic feedback_sense_uv,
	input wire logic feedback_sense_ov,
	input wire logic feedback_sense_pg_low,
	input wire logic feedback_sense_pg_high,
	input wire logic switch_node_high,
	input wire logic ls_fully_on,
	input wire logic current_limit,
	input wire logic temp_hot,
	input wire logic temp_cool,
	input wire logic power_good_out_i,
	output logic power_good_out_o,
	output logic power_good_out_oe,
	output logic hs_enable,
	output logic ls_enable,
	output logic ls_sync_enable,
	output logic en_sink_on,
	output logic en_pullup_on,
	output logic fault_latched,
	output logic [rfs_pkg::RAMP_W-1:0] ss_ramp,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	rfs_state_t state, next_state;
	logic [RAMP_W-1:0] next_ss_ramp;
	logic [4:0] uv_cnt, ov_cnt, oc_cnt, pgl_cnt, pgh_cnt;
	logic [4:0] next_uv_cnt, next_ov_cnt, next_oc_cnt, next_pgl_cnt, next_pgh_cnt;
	logic en_level, next_en_level, ot_hold, next_ot_hold;
	logic force_off, next_force_off;
	logic [CAUSE_W-1:0] cause, next_cause, set_cause;
	logic active, go_off, uv_armed;

	// consecutive-cycle counter step, saturating at its trip count
	function automatic logic [4:0] run_count(input logic [4:0] cnt, input logic cond,
		input logic tick, input logic arm, input logic [4:0] lim);
		logic [4:0] r;
		r = cnt;
		if (!arm || (tick && !cond)) begin
			r = 5'd0;
		end else if (tick && cnt < lim) begin
			r = cnt + 5'd1;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// supervision state: the ramp is only meaningful while a start is under way
	always_comb begin
		active = (state == ST_RAMP) || (state == ST_RUN);
		uv_armed = active && (ss_ramp >= FAULT_ENABLE_POINT);
		// enable comparator hysteresis: rise at upper, fall at lower threshold
		next_en_level = en_level;
		if (en_above_rise) begin
			next_en_level = 1'b1;
		end else if (!en_above_fall) begin
			next_en_level = 1'b0;
		end
		next_ot_hold = ot_hold;
		if (temp_hot) begin
			next_ot_hold = 1'b1;
		end else if (temp_cool) begin
			next_ot_hold = 1'b0;
		end
		next_uv_cnt = run_count(uv_cnt, feedback_sense_uv, osc_tick, uv_armed, UV_CYCLES);
		next_ov_cnt = run_count(ov_cnt, feedback_sense_ov, osc_tick, active, OV_CYCLES);
		next_oc_cnt = run_count(oc_cnt, current_limit, osc_tick, active, OC_CYCLES);
		next_pgl_cnt = run_count(pgl_cnt, feedback_sense_pg_low, osc_tick, active, PG_CYCLES);
		next_pgh_cnt = run_count(pgh_cnt, feedback_sense_pg_high, osc_tick, active, PG_CYCLES);
		set_cause = '0;
		set_cause[C_UV] = next_uv_cnt == UV_CYCLES;
		set_cause[C_OV] = next_ov_cnt == OV_CYCLES;
		set_cause[C_HS] = active && switch_node_high && ls_fully_on;
		set_cause[C_OC] = next_oc_cnt == OC_CYCLES;
		set_cause[C_OT] = active && temp_hot;
		go_off = supply_lockout || (en_level && !next_en_level) || force_off;
		next_state = state;
		next_ss_ramp = ss_ramp;
		case (state)
			ST_OFF: begin
				next_ss_ramp = '0;
				if (en_level && !supply_lockout && !ot_hold && !force_off) begin
					next_state = ST_SHORT_CHK;
				end
			end
			ST_SHORT_CHK: begin
				if (!feedback_sense_short) begin
					next_state = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (osc_tick) begin
					next_ss_ramp = ss_ramp + RAMP_STEP;
				end
				if (ss_ramp >= FAULT_ENABLE_POINT) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			ST_FAULT: begin
				next_state = ST_FAULT;
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		if (set_cause != '0) begin
			next_state = ST_FAULT;
		end
		if (go_off) begin
			next_state = ST_OFF;
			next_ss_ramp = '0;
		end
	end

	// supervision registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_OFF;
			ss_ramp <= '0;
			uv_cnt <= '0;
			ov_cnt <= '0;
			oc_cnt <= '0;
			pgl_cnt <= '0;
			pgh_cnt <= '0;
			en_level <= 1'b0;
			ot_hold <= 1'b0;
		end else begin
			state <= next_state;
			ss_ramp <= next_ss_ramp;
			uv_cnt <= next_uv_cnt;
			ov_cnt <= next_ov_cnt;
			oc_cnt <= next_oc_cnt;
			pgl_cnt <= next_pgl_cnt;
			pgh_cnt <= next_pgh_cnt;
			en_level <= next_en_level;
			ot_hold <= next_ot_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin outputs come from flops fed by the next state, so they track state exactly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_enable <= 1'b0;
			ls_enable <= 1'b0;
			ls_sync_enable <= 1'b0;
			en_sink_on <= 1'b0;
			en_pullup_on <= 1'b1;
			fault_latched <= 1'b0;
			power_good_out_o <= 1'b0;
			power_good_out_oe <= 1'b1;
		end else begin
			hs_enable <= (next_state == ST_RAMP) || (next_state == ST_RUN);
			ls_enable <= (next_state == ST_RAMP) || (next_state == ST_RUN);
			ls_sync_enable <= ((next_state == ST_RAMP) || (next_state == ST_RUN))
				&& (next_ss_ramp >= SYNC_POINT);
			en_sink_on <= next_state == ST_FAULT;
			en_pullup_on <= next_state != ST_FAULT;
			fault_latched <= next_state == ST_FAULT;
			power_good_out_o <= 1'b0; // open drain never drives high
			power_good_out_oe <= !((next_state == ST_RUN)
				&& (next_ss_ramp >= FAULT_ENABLE_POINT)
				&& (next_pgl_cnt != PG_CYCLES) && (next_pgh_cnt != PG_CYCLES));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave: address and data taken in either order, one of each at a time
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic w_lane0, next_w_lane0;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, status_word;

	always_comb begin
		status_word = '0;
		status_word[2:0] = state;
		status_word[ST_FAULT_BIT] = state == ST_FAULT;
		status_word[ST_PG_BIT] = !power_good_out_oe;
		status_word[ST_EN_BIT] = en_level;
		status_word[ST_PIN_BIT] = power_good_out_i;
		status_word[ST_RAMP_LSB +: RAMP_W] = ss_ramp;
		next_aw_held = aw_held || s_axi_awvalid;
		next_aw_addr = aw_held ? aw_addr : s_axi_awaddr[7:0];
		next_w_held = w_held || s_axi_wvalid;
		next_w_data = w_held ? w_data : s_axi_wdata;
		next_w_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_force_off = force_off;
		// hardware set wins over a write-one-to-clear in the same cycle
		next_cause = cause | set_cause;
		if (aw_held && w_held && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (aw_addr == CTRL_OFS) begin
				if (w_lane0) begin
					next_force_off = w_data[0];
				end
			end else if (aw_addr == CAUSE_OFS) begin
				if (w_lane0) begin
					next_cause = (cause & ~w_data[CAUSE_W-1:0]) | set_cause;
				end
			end else if (aw_addr != STATUS_OFS) begin
				next_bresp = RESP_SLVERR;
			end
		end
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			case (s_axi_araddr[7:0])
				CTRL_OFS: next_rdata = {31'h0, force_off};
				STATUS_OFS: next_rdata = status_word;
				CAUSE_OFS: next_rdata = {27'h0, cause};
				default: begin
					next_rdata = '0;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	// bus registers; ready flags are the inverse of the next holding state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			force_off <= 1'b0;
			cause <= '0;
		end else begin
			aw_held <= next_aw_held && !(s_axi_awvalid && !s_axi_awready && !aw_held);
			w_held <= next_w_held && !(s_axi_wvalid && !s_axi_wready && !w_held);
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			s_axi_awready <= !next_aw_held || (s_axi_awvalid && !s_axi_awready && !aw_held);
			s_axi_wready <= !next_w_held || (s_axi_wvalid && !s_axi_wready && !w_held);
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			force_off <= next_force_off;
			cause <= next_cause;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks on the supervision behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_calm;
		!supply_lockout && !force_off && !(en_level && !en_above_fall && !en_above_rise);
	endsequence
	property p_short_hold;
		(state == ST_SHORT_CHK && feedback_sense_short) |=> state != ST_RAMP;
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("ramp released on short");
	property p_ramp_step;
		(state == ST_RAMP && !osc_tick && set_cause == '0) ##0 s_calm |=> $stable(ss_ramp);
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("ramp moved without tick");
	property p_lockout;
		supply_lockout |=> (state == ST_OFF) && (ss_ramp == '0) && !hs_enable;
	endproperty
	a_lockout: assert property (p_lockout) else $error("lockout did not reset");
	property p_sync;
		ls_sync_enable |-> ss_ramp >= SYNC_POINT;
	endproperty
	a_sync: assert property (p_sync) else $error("sync mode before 95 percent");
	property p_uv;
		(uv_cnt == UV_CYCLES - 5'd1 && osc_tick && feedback_sense_uv && uv_armed) ##0 s_calm
			|=> fault_latched ##1 !hs_enable;
	endproperty
	a_uv: assert property (p_uv) else $error("uv run did not trip");
	property p_uv_gate;
		(active && ss_ramp < FAULT_ENABLE_POINT) |-> uv_cnt == 5'd0;
	endproperty
	a_uv_gate: assert property (p_uv_gate) else $error("uv counted before fault point");
	property p_ov;
		(ov_cnt == OV_CYCLES - 5'd1 && osc_tick && feedback_sense_ov && active) ##0 s_calm
			|=> fault_latched;
	endproperty
	a_ov: assert property (p_ov) else $error("ov run did not trip");
	property p_hs;
		(active && switch_node_high && ls_fully_on) ##0 s_calm |=> fault_latched && !ls_enable;
	endproperty
	a_hs: assert property (p_hs) else $error("high-side short not latched");
	property p_sink;
		fault_latched |-> en_sink_on && !en_pullup_on && !hs_enable && !ls_enable;
	endproperty
	a_sink: assert property (p_sink) else $error("fault without sink or switches on");
	property p_pg_early;
		!power_good_out_oe |-> ss_ramp >= FAULT_ENABLE_POINT;
	endproperty
	a_pg_early: assert property (p_pg_early) else $error("power good before fault point");
endmodule
`default_nettype wire

// *** common/rfs_pkg.sv ***
// rfs_pkg: constants shared by the regulator fault sequencer
// assumes ramp values in millivolts and one osc tick per switching cycle
`default_nettype none
package rfs_pkg;
	// soft-start ramp points, millivolts
	localparam int RAMP_W = 11;
	localparam logic [10:0] REGULATION_POINT = 11'h320;
	localparam logic [10:0] FAULT_ENABLE_POINT = 11'h3E8;
	localparam logic [10:0] SYNC_POINT = 11'h2F8; // 95% of reference
	localparam logic [10:0] RAMP_STEP = 11'h001;
	// consecutive switching-cycle counts
	localparam logic [4:0] UV_CYCLES = 5'h10;
	localparam logic [4:0] OC_CYCLES = 5'h10;
	localparam logic [4:0] OV_CYCLES = 5'h02;
	localparam logic [4:0] PG_CYCLES = 5'h02;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] CAUSE_OFS = 8'h08;
	// fault cause bit positions
	localparam int C_UV = 0;
	localparam int C_OV = 1;
	localparam int C_HS = 2;
	localparam int C_OC = 3;
	localparam int C_OT = 4;
	localparam int CAUSE_W = 5;
	// status field positions
	localparam int ST_FAULT_BIT = 3;
	localparam int ST_PG_BIT = 4;
	localparam int ST_EN_BIT = 5;
	localparam int ST_PIN_BIT = 6;
	localparam int ST_RAMP_LSB = 16;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SHORT_CHK = 3'b001,
		ST_RAMP = 3'b010,
		ST_RUN = 3'b011,
		ST_FAULT = 3'b100
	} rfs_state_t;
endpackage
`default_nettype wire

// *** test/rfs_partner.sv ***
// rfs_partner: enable pin and power-good pin as seen from the system side
// assumes one aclk domain; the enable pin voltage is kept in millivolts
`timescale 1ns/1ps
`default_nettype none
module rfs_partner (
	input wire logic aclk,
	input wire logic [1:0] en_mode,
	input wire logic en_sink_on,
	input wire logic en_pullup_on,
	input wire logic power_good_out_o,
	input wire logic power_good_out_oe,
	output logic en_above_rise,
	output logic en_above_fall,
	output logic power_good_out_i
);
	int en_mv = 0;
	////////////////////////////////////////////////////////////////////////////////
	// enable pin: 0 open, 1 held low, 2 held high, 3 capacitor to ground
	// capacitor slows recharge
	always @(posedge aclk) begin
		if (en_mode == 2'h1)
			en_mv <= 0;
		else if (en_mode == 2'h2)
			en_mv <= 5000;
		else if (en_sink_on && en_mv >= 20)
			en_mv <= en_mv - 20;
		else if (en_pullup_on && en_mv < 5000)
			en_mv <= en_mv + ((en_mode == 2'h3) ? 5 : 50);
	end
	// pin comparators; the lower threshold gives the restart hysteresis
	assign en_above_rise = (en_mv > 1350);
	assign en_above_fall = (en_mv > 1100);
	// pulled up when released, so a released pin never shows a stale level
	assign power_good_out_i = (power_good_out_oe && !power_good_out_o) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// *** test/rfs_sequencer_tb.sv ***
// rfs_sequencer_tb: self-checking bench for the regulator fault sequencer
// assumes rfs_partner on the enable and power-good pins; comparators driven by the bench
`timescale 1ns/1ps
`default_nettype none
module rfs_sequencer_tb;
	import rfs_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, osc_tick = 1'h0, supply_lockout = 1'h1;
	logic temp_hot = 1'h0, temp_cool = 1'h1;
	logic [7:0] cnd = 8'h08;
	logic [1:0] en_mode = 2'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd;
	logic en_above_rise, en_above_fall, power_good_out_i, power_good_out_o, power_good_out_oe;
	logic hs_enable, ls_enable, ls_sync_enable, en_sink_on, en_pullup_on, fault_latched;
	logic [RAMP_W-1:0] ss_ramp;
	int num_errors = 0, cmp_count = 0;
	////////////////////////////////////////////////////////////////////////////////
	// 200 MHz clock; switching tick every second cycle keeps ramp runs short
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) osc_tick <= ~osc_tick;
	rfs_sequencer u_rfs_sequencer (.aclk, .aresetn, .osc_tick, .supply_lockout, .en_above_rise,
		.en_above_fall, .feedback_sense_short(cnd[3]), .feedback_sense_uv(cnd[0]),
		.feedback_sense_ov(cnd[1]), .feedback_sense_pg_low(cnd[4]),
		.feedback_sense_pg_high(cnd[5]), .switch_node_high(cnd[6]), .ls_fully_on(cnd[7]),
		.current_limit(cnd[2]), .temp_hot, .temp_cool, .power_good_out_i, .power_good_out_o,
		.power_good_out_oe, .hs_enable, .ls_enable, .ls_sync_enable, .en_sink_on, .en_pullup_on,
		.fault_latched, .ss_ramp, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	rfs_partner u_rfs_partner (.aclk, .en_mode, .en_sink_on, .en_pullup_on, .power_good_out_o,
		.power_good_out_oe, .en_above_rise, .en_above_fall, .power_good_out_i);
	////////////////////////////////////////////////////////////////////////////////
	// verdict and compare helpers
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// bounded wait for ramp (0), high-side enable (1) or fault latch (2) to reach v
	task automatic wt(input int s, input logic [10:0] v);
		for (int k = 0; k < 6000; k++) begin
			@(posedge aclk);
			#1;
			if ((s == 0 ? ss_ramp : s == 1 ? {10'h0, hs_enable} : {10'h0, fault_latched}) === v)
				return;
		end
		chk(32'h0, 32'h1);
		stop_test();
	endtask
	// counts advance only on tick edges, so waits are in ticks
	task automatic ticks(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			// bounded: a stuck tick must end the run, not hang it
			for (int k = 0; k < 4 && osc_tick !== 1'h1; k++)
				@(posedge aclk);
			if (osc_tick !== 1'h1) begin
				chk(32'h0, 32'h1);
				stop_test();
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// bus master: address and data offered together, each released when taken
	task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_bvalid && ad && wd) begin
				s_axi_bready <= 1'h0;
				chk(s_axi_bresp, er);
				return;
			end
			if (s_axi_awready && !ad) begin
				ad = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wready && !wd) begin
				wd = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		chk(32'h0, 32'h1);
		stop_test();
	endtask
	task automatic axr(input logic [31:0] a, input logic [1:0] er);
		logic ad;
		ad = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_rvalid && ad) begin
				s_axi_rready <= 1'h0;
				rd = s_axi_rdata;
				chk(s_axi_rresp, er);
				return;
			end
			if (s_axi_arready && !ad) begin
				ad = 1'h1;
				s_axi_arvalid <= 1'h0;
			end
		end
		chk(32'h0, 32'h1);
		stop_test();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// raise a fault condition for n ticks (0: immediate) and check the latch timing
	task automatic trip(input logic [7:0] m, input int n);
		@(posedge aclk);
		cnd <= cnd | m;
		if (n > 0) begin
			ticks(n - 1);
			@(posedge aclk);
			#1 chk(fault_latched, 1'h0);
			ticks(1);
		end else
			@(posedge aclk);
		@(posedge aclk);
		#1 chk(fault_latched, 1'h1);
		chk({hs_enable, ls_enable, en_sink_on, en_pullup_on}, 4'h2);
		@(posedge aclk);
		cnd <= cnd & ~m;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenario: unmapped and control registers, forced off, short check, first ramp steps
	task automatic test_start;
		axr(32'h10, RESP_SLVERR);
		chk(rd, 32'h0);
		axw(32'h10, 32'h0, RESP_SLVERR);
		axw(CTRL_OFS, 32'h1, RESP_OKAY);
		axr(CTRL_OFS, RESP_OKAY);
		chk(rd[0], 1'h1);
		axw(STATUS_OFS, 32'hFFFFFFFF, RESP_OKAY);
		supply_lockout <= 1'h0;
		repeat (40) @(posedge aclk);
		axw(CTRL_OFS, 32'h0, RESP_OKAY);
		repeat (40) @(posedge aclk);
		axr(STATUS_OFS, RESP_OKAY);
		chk(rd[3:0], 4'h1);
		chk({hs_enable, ss_ramp}, 12'h0);
		cnd[3] <= 1'h0;
		wt(1, 11'h1);
		wt(0, 11'h64);
		repeat (20) @(posedge aclk);
		#1 chk(ss_ramp, 11'h6E);
		$display("test start done");
	endtask
	// scenario: faults during soft-start, cause register and auto-restart
	task automatic test_ramp_faults;
		trip(8'h02, 2);
		axr(CAUSE_OFS, RESP_OKAY);
		chk(rd[4:0], 5'h2);
		axw(CAUSE_OFS, 32'h2, RESP_OKAY);
		axr(CAUSE_OFS, RESP_OKAY);
		chk(rd[4:0], 5'h0);
		wt(1, 11'h1);
		trip(8'hC0, 0);
		wt(1, 11'h1);
		trip(8'h04, 16);
		wt(1, 11'h1);
		$display("test ramp faults done");
	endtask
	// scenario: pre-bias, under-voltage gating, power-good window and run faults
	task automatic test_run_faults;
		cnd[0] <= 1'h1;
		wt(0, SYNC_POINT - 11'h1);
		chk(ls_sync_enable, 1'h0);
		wt(0, SYNC_POINT + 11'h1);
		chk(ls_sync_enable, 1'h1);
		wt(0, FAULT_ENABLE_POINT - 11'h1);
		chk({fault_latched, power_good_out_oe}, 2'h1);
		@(posedge aclk);
		cnd[0] <= 1'h0;
		wt(0, FAULT_ENABLE_POINT);
		ticks(4);
		@(posedge aclk);
		#1 chk({power_good_out_oe, power_good_out_i}, 2'h1);
		// status: ramp parked at fault point, run, good, enable high, pin released
		axr(STATUS_OFS, RESP_OKAY);
		chk(rd, {5'h00, FAULT_ENABLE_POINT, 9'h000, 3'h7, 1'h0, ST_RUN});
		for (int b = 4; b < 6; b++) begin
			@(posedge aclk);
			cnd[b] <= 1'h1;
			ticks(1);
			@(posedge aclk);
			#1 chk(power_good_out_oe, 1'h0);
			ticks(1);
			@(posedge aclk);
			#1 chk({power_good_out_oe, power_good_out_i}, 2'h2);
			@(posedge aclk);
			cnd[b] <= 1'h0;
			ticks(3);
			@(posedge aclk);
			#1 chk(power_good_out_oe, 1'h0);
		end
		@(posedge aclk);
		cnd[0] <= 1'h1;
		ticks(15);
		cnd[0] <= 1'h0;
		ticks(1);
		trip(8'h01, 16);
		wt(1, 11'h1);
		$display("test run faults done");
	endtask
	// scenario: over-temperature hold, supply lockout and enable toggle
	task automatic test_restart;
		@(posedge aclk);
		temp_hot <= 1'h1;
		temp_cool <= 1'h0;
		repeat (2) @(posedge aclk);
		#1 chk(fault_latched, 1'h1);
		@(posedge aclk);
		temp_hot <= 1'h0;
		repeat (600) @(posedge aclk);
		#1 chk(hs_enable, 1'h0);
		@(posedge aclk);
		temp_cool <= 1'h1;
		wt(1, 11'h1);
		wt(0, 11'h32);
		@(posedge aclk);
		supply_lockout <= 1'h1;
		repeat (2) @(posedge aclk);
		#1 chk({hs_enable, ss_ramp}, 12'h0);
		@(posedge aclk);
		supply_lockout <= 1'h0;
		wt(0, 11'h32);
		@(posedge aclk);
		en_mode <= 2'h1;
		wt(1, 11'h0);
		repeat (2) @(posedge aclk);
		#1 chk(ss_ramp, 11'h0);
		@(posedge aclk);
		en_mode <= 2'h0;
		wt(1, 11'h1);
		$display("test restart done");
	endtask
	// scenario: enable held high latches off, capacitor delays the restart
	task automatic test_latched;
		@(posedge aclk);
		// enable driven high only with supply up
		en_mode <= 2'h2;
		trip(8'hC0, 0);
		repeat (400) @(posedge aclk);
		#1 chk({fault_latched, hs_enable}, 2'h2);
		@(posedge aclk);
		en_mode <= 2'h1;
		wt(2, 11'h0);
		@(posedge aclk);
		en_mode <= 2'h3;
		repeat (200) @(posedge aclk);
		#1 chk(hs_enable, 1'h0);
		wt(1, 11'h1);
		$display("test latched done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence: reset, then each scenario in turn
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		test_start();
		test_ramp_faults();
		test_run_faults();
		test_restart();
		test_latched();
		stop_test();
	end
endmodule
`default_nettype wire
